// ==== verilog/sep_dev.sv ====
// eeprom end: link logic on scl, rewrite timer on clk
`timescale 1ns/1ps
`default_nettype none
module sep_dev import sep_pkg::*; #(
    parameter int MEM_WORDS = MEM_WORDS_DEF,
    parameter int WR_CYC = WR_CYC_DEF
) (
    input wire logic clk,           // system clock
    input wire logic reset,         // async reset, high
    sep_if.device bus,              // two-wire link
    input wire logic [2:0] strap_addr, // address straps
    input wire logic wp,            // write protect pin
    output logic busy               // rewrite in progress
);
    localparam bit FOURK = (MEM_WORDS == 512);
    localparam bit HAS_WP = (MEM_WORDS != 128);
    localparam logic [8:0] AMASK = 9'(MEM_WORDS - 1);
    localparam logic [8:0] PMASK = FOURK ? 9'h00f : 9'h007;
    localparam logic [8:0] UPPER = 9'(MEM_WORDS / 2);
    localparam logic [15:0] WR_LAST = 16'(WR_CYC - 1);

    function automatic logic [8:0] inc_seq(input logic [8:0] p);
        inc_seq = (p + 9'h001) & AMASK;
    endfunction

    function automatic logic [8:0] inc_page(input logic [8:0] p);
        inc_page = (p & ~PMASK) | ((p + 9'h001) & PMASK);
    endfunction

    logic start_tgl_q;
    logic stop_tgl_q;
    logic start_seen_q;
    logic fst_q;
    logic mack_q;
    logic [3:0] cnt_q;
    logic [7:0] sh_q;
    logic stop_seen_q;
    logic oe_q;
    logic p0_q;
    logic wr_pend_q;
    sep_dst_e st_q;
    logic [8:0] ptr_q;
    logic [7:0] tx_q;
    logic [7:0] pg_q [PAGE_MAX];
    logic [PAGE_MAX-1:0] pg_v_q;
    logic [7:0] mem_q [MEM_WORDS];
    logic [3:0] pin_s1_q;
    logic [3:0] pin_s2_q;
    logic bsy_s1_q;
    logic bsy_s2_q;
    logic [2:0] stop_sy_q;
    logic [1:0] pend_sy_q;
    logic [15:0] wr_cnt_q;
    logic busy_q;
    logic addr_hit;
    logic prot;
    logic take_wr;
    logic commit;
    logic [3:0] pidx;

    // start and stop seen as data edges while scl is high
    always_ff @(negedge bus.sda or posedge reset) begin
        if (reset) begin
            start_tgl_q <= 1'b0;
        end else if (bus.scl) begin
            start_tgl_q <= ~start_tgl_q;
        end
    end

    always_ff @(posedge bus.sda or posedge reset) begin
        if (reset) begin
            stop_tgl_q <= 1'b0;
        end else if (bus.scl) begin
            stop_tgl_q <= ~stop_tgl_q;
        end
    end

    // pins and busy level into the link domain
    always_ff @(posedge bus.scl or posedge reset) begin
        if (reset) begin
            pin_s1_q <= PIN_RST;
            pin_s2_q <= PIN_RST;
            bsy_s1_q <= 1'b0;
            bsy_s2_q <= 1'b0;
        end else begin
            pin_s1_q <= {wp, strap_addr};
            pin_s2_q <= pin_s1_q;
            bsy_s1_q <= busy_q;
            bsy_s2_q <= bsy_s1_q;
        end
    end

    // bit sampling on rising scl
    always_ff @(posedge bus.scl or posedge reset) begin
        if (reset) begin
            start_seen_q <= 1'b0;
            fst_q <= 1'b0;
            cnt_q <= 4'h0;
            sh_q <= 8'h00;
            mack_q <= 1'b0;
        end else if (start_tgl_q != start_seen_q) begin
            start_seen_q <= start_tgl_q;
            fst_q <= 1'b1;
            cnt_q <= 4'h1;
            sh_q <= {7'h00, bus.sda};
        end else if (cnt_q == BIT_ACK) begin
            cnt_q <= 4'h0;
            fst_q <= 1'b0;
            mack_q <= ~bus.sda; // [RULE_15]
        end else begin
            cnt_q <= cnt_q + 4'h1;
            sh_q <= {sh_q[6:0], bus.sda};
        end
    end

    assign addr_hit = (sh_q[7:4] == DEV_CODE) // [RULE_18]
        && (FOURK ? sh_q[3:2] == pin_s2_q[2:1]
                  : sh_q[3:1] == pin_s2_q[2:0]);
    assign prot = HAS_WP && pin_s2_q[3] // [RULE_04] [RULE_06]
        && ((ptr_q & UPPER) != 9'h000);
    assign take_wr = (cnt_q == BIT_ACK) && !fst_q
        && (st_q == SD_WDATA) && !prot;
    assign commit = fst_q && (cnt_q == 4'h1) && wr_pend_q
        && (stop_tgl_q != stop_seen_q); // [RULE_20]
    assign pidx = ptr_q[3:0] & PMASK[3:0];

    // byte decisions and data drive on falling scl
    always_ff @(negedge bus.scl or posedge reset) begin
        if (reset) begin
            st_q <= SD_IDLE;
            oe_q <= 1'b0;
            ptr_q <= PTR_RST;
            p0_q <= 1'b0;
            wr_pend_q <= 1'b0;
            stop_seen_q <= 1'b0;
            tx_q <= 8'h00;
            pg_v_q <= '0;
        end else begin
            if (fst_q && cnt_q == 4'h1) begin
                stop_seen_q <= stop_tgl_q;
                // a write not closed by stop is dropped
                wr_pend_q <= 1'b0;
            end
            if (fst_q && cnt_q == BIT_ACK) begin
                if (addr_hit && !bsy_s2_q) begin // [RULE_01] [RULE_02]
                    oe_q <= 1'b1; // [RULE_19] [RULE_08]
                    // read keeps the pointer as is [RULE_09]
                    st_q <= sh_q[0] ? SD_READ : SD_WADDR;
                    if (!sh_q[0] && FOURK) begin
                        p0_q <= sh_q[1];
                    end
                end else begin
                    oe_q <= 1'b0; // [RULE_23]
                    st_q <= SD_IDLE;
                end
            end else if (cnt_q == BIT_ACK) begin
                case (st_q)
                    SD_WADDR: begin
                        // [RULE_13] [RULE_14]
                        ptr_q <= {FOURK ? p0_q : 1'b0, sh_q} & AMASK;
                        pg_v_q <= '0;
                        oe_q <= 1'b1;
                        st_q <= SD_WDATA;
                    end
                    SD_WDATA: begin
                        if (!prot) begin
                            pg_v_q[pidx] <= 1'b1;
                        end
                        wr_pend_q <= 1'b1; // [RULE_05]
                        ptr_q <= inc_page(ptr_q); // [RULE_12] [RULE_17] [RULE_21]
                        oe_q <= 1'b1;
                    end
                    SD_READ: begin
                        ptr_q <= inc_seq(ptr_q); // [RULE_10] [RULE_16] [RULE_07]
                        oe_q <= 1'b0;
                    end
                    default: begin
                        oe_q <= 1'b0;
                    end
                endcase
            end else if (cnt_q == 4'h0) begin
                if (st_q == SD_READ && mack_q) begin // [RULE_15]
                    oe_q <= ~mem_q[ptr_q][7]; // [RULE_08]
                    tx_q <= {mem_q[ptr_q][6:0], 1'b0};
                end else begin
                    oe_q <= 1'b0;
                    if (st_q == SD_READ) begin
                        st_q <= SD_IDLE;
                    end
                end
            end else if (st_q == SD_READ && !fst_q) begin
                oe_q <= ~tx_q[7];
                tx_q <= {tx_q[6:0], 1'b0};
            end else begin
                oe_q <= 1'b0;
            end
        end
    end

    // page buffer and array; rewrite lands at next frame
    always_ff @(negedge bus.scl) begin
        if (take_wr) begin
            pg_q[pidx] <= sh_q;
        end
        for (int i = 0; i < PAGE_MAX; i++) begin
            if (commit && pg_v_q[i] && 9'(i) <= PMASK) begin
                mem_q[(ptr_q & ~PMASK) | 9'(i)] <= pg_q[i];
            end
        end
    end

    // stop event and write-pending level into clk domain
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            stop_sy_q <= 3'h0;
            pend_sy_q <= 2'h0;
        end else begin
            stop_sy_q <= {stop_sy_q[1:0], stop_tgl_q};
            pend_sy_q <= {pend_sy_q[0], wr_pend_q};
        end
    end

    // rewrite busy period
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            busy_q <= 1'b0;
            wr_cnt_q <= 16'h0000;
        end else if ((stop_sy_q[2] != stop_sy_q[1]) && pend_sy_q[1]) begin
            busy_q <= 1'b1; // [RULE_20] [RULE_22]
            wr_cnt_q <= WR_LAST;
        end else if (wr_cnt_q != 16'h0000) begin
            wr_cnt_q <= wr_cnt_q - 16'h0001;
        end else begin
            busy_q <= 1'b0;
        end
    end

    assign busy = busy_q;
    assign bus.sda_d_o = 1'b0;
    assign bus.sda_d_oe = oe_q;
endmodule // sep_dev
`default_nettype wire

// ==== verilog/sep_pkg.sv ====
// package: constants and enums for the serial eeprom link
// Behaviour
// [RULE_01] rewriting device ignores bus, gives no acks
// [RULE_02] poll: address acked means rewrite done
// [RULE_03] master polls with read direction bit
// [RULE_04] protect pin high blocks upper-half writes
// [RULE_05] blocked write still keeps device busy
// [RULE_06] protect pin low allows all writes
// [RULE_07] pointer keeps last accessed location; code keeps the address after the last one accessed
// [RULE_08] read address acked, byte at pointer out
// [RULE_09] 4k current read ignores page bit
// [RULE_10] read pointer steps after eighth bit
// [RULE_11] master ends read with nack, stop
// [RULE_12] writes advance only in-page address bits
// [RULE_13] dummy write loads pointer, stores nothing
// [RULE_14] restart with read returns loaded address
// [RULE_15] master ack requests next byte
// [RULE_16] sequential read wraps at array end
// [RULE_17] write pointer steps after eighth bit
// [RULE_18] answer only to code 1010 and straps
// [RULE_19] ack by pulling data low, ninth clock
// [RULE_20] stop ends write into rewrite, read idle
// [RULE_21] page data past page size wraps
// [RULE_22] busy counter and depth variant parameter
// [RULE_23] data line released while busy
`default_nettype none
package sep_pkg;
    localparam int CLK_NS = 20;
    localparam int SCL_PERIOD_NS = 2_000;
    localparam int QTR_CYC = SCL_PERIOD_NS / (4 * CLK_NS);
    localparam int WR_TIME_NS = 1_000_000;
    localparam int WR_CYC_DEF = WR_TIME_NS / CLK_NS;
    localparam int MEM_WORDS_DEF = 512;
    localparam int PAGE_MAX = 16;
    localparam logic [3:0] DEV_CODE = 4'ha;
    localparam logic [3:0] BIT_ACK = 4'h8;
    localparam logic [8:0] PTR_RST = 9'h000;
    localparam logic [3:0] PIN_RST = 4'h0;
    localparam logic [7:0] QTR_RST = 8'h00;
    typedef enum logic [1:0] {
        SEP_OP_WRITE,
        SEP_OP_READ_CUR,
        SEP_OP_READ_RAND
    } sep_op_e;
    typedef enum {SD_IDLE, SD_WADDR, SD_WDATA, SD_READ} sep_dst_e;
    typedef enum {SM_IDLE, SM_START, SM_BIT, SM_STOP} sep_mst_e;
    typedef enum {SB_DEV, SB_ADDR, SB_WDATA, SB_RDEV, SB_RDATA} sep_stg_e;
endpackage
`default_nettype wire

// ==== verilog/sep_if.sv ====
// interface: two-wire link between master and eeprom ends
`timescale 1ns/1ps
`default_nettype none
interface sep_if;
    logic scl;
    logic sda_m_o;
    logic sda_m_oe;
    logic sda_d_o;
    logic sda_d_oe;
    logic sda;
    // open drain with pull-up
    assign sda = ~(sda_m_oe & ~sda_m_o) & ~(sda_d_oe & ~sda_d_o);
    modport master (
        output scl,
        output sda_m_o,
        output sda_m_oe,
        input sda
    );
    modport device (
        input scl,
        input sda,
        output sda_d_o,
        output sda_d_oe
    );
endinterface
`default_nettype wire

// ==== verilog/sep_mst.sv ====
// master end: scl divider and byte sequencer
`timescale 1ns/1ps
`default_nettype none
module sep_mst import sep_pkg::*; #(
    parameter int MEM_WORDS = MEM_WORDS_DEF
) (
    input wire logic clk,            // system clock
    input wire logic reset,          // async reset, high
    sep_if.master bus,               // two-wire link
    input wire logic cmd_valid,      // command request
    input wire sep_op_e cmd_op,      // operation
    input wire logic [2:0] cmd_dev,  // device straps
    input wire logic [8:0] cmd_addr, // word address
    input wire logic [7:0] cmd_len,  // byte count
    input wire logic [7:0] cmd_wdata, // write byte
    output logic cmd_ready,          // idle, takes command
    output logic wd_take,            // write byte consumed
    output logic rd_valid,           // read byte strobe
    output logic [7:0] rd_data,      // read byte
    output logic done,               // command finished
    output logic nack                // address or byte refused
);
    localparam bit FOURK = (MEM_WORDS == 512);
    localparam logic [7:0] QTR_LAST = 8'(QTR_CYC - 1);

    logic [7:0] q_cnt_q;
    logic tick;
    logic [1:0] ph_q;
    sep_mst_e st_q;
    sep_stg_e stg_q;
    sep_op_e op_q;
    logic [2:0] dev_q;
    logic [8:0] addr_q;
    logic [7:0] rem_q;
    logic [7:0] tx_q;
    logic [7:0] rx_q;
    logic [3:0] bit_q;
    logic ack_q;
    logic [1:0] sda_sy_q;
    logic scl_q;
    logic oe_q;
    logic rdy_q;
    logic take_q;
    logic rdv_q;
    logic done_q;
    logic nack_q;
    logic [7:0] rdd_q;

    function automatic logic [7:0] dev_byte(input logic rd);
        dev_byte = {DEV_CODE, dev_q[2:1], FOURK ? addr_q[8] : dev_q[0], rd};
    endfunction

    // quarter-bit timebase
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            q_cnt_q <= QTR_RST;
        end else if (q_cnt_q == QTR_LAST) begin
            q_cnt_q <= QTR_RST;
        end else begin
            q_cnt_q <= q_cnt_q + 8'h01;
        end
    end
    assign tick = (q_cnt_q == QTR_LAST);

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sda_sy_q <= 2'h3;
        end else begin
            sda_sy_q <= {sda_sy_q[0], bus.sda};
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            st_q <= SM_IDLE;
            stg_q <= SB_DEV;
            op_q <= SEP_OP_WRITE;
            ph_q <= 2'h0;
            dev_q <= 3'h0;
            addr_q <= PTR_RST;
            rem_q <= 8'h00;
            tx_q <= 8'h00;
            rx_q <= 8'h00;
            bit_q <= 4'h0;
            ack_q <= 1'b0;
            scl_q <= 1'b1;
            oe_q <= 1'b0;
            rdy_q <= 1'b1;
            take_q <= 1'b0;
            rdv_q <= 1'b0;
            done_q <= 1'b0;
            nack_q <= 1'b0;
            rdd_q <= 8'h00;
        end else begin
            take_q <= 1'b0;
            rdv_q <= 1'b0;
            done_q <= 1'b0;
            case (st_q)
                SM_IDLE: if (cmd_valid) begin
                    op_q <= cmd_op;
                    dev_q <= cmd_dev;
                    addr_q <= cmd_addr;
                    rem_q <= (cmd_len == 8'h00) ? 8'h01 : cmd_len;
                    nack_q <= 1'b0;
                    rdy_q <= 1'b0;
                    ph_q <= 2'h0;
                    st_q <= SM_START;
                    stg_q <= (cmd_op == SEP_OP_READ_CUR) ? SB_RDEV : SB_DEV;
                end
                SM_START: if (tick) begin
                    ph_q <= ph_q + 2'h1;
                    case (ph_q)
                        2'h0: oe_q <= 1'b0;
                        2'h1: scl_q <= 1'b1;
                        2'h2: oe_q <= 1'b1;
                        default: begin
                            scl_q <= 1'b0;
                            bit_q <= 4'h0;
                            st_q <= SM_BIT;
                            // polls go out as reads [RULE_03] [RULE_14]
                            tx_q <= dev_byte(stg_q == SB_RDEV);
                        end
                    endcase
                end
                SM_BIT: if (tick) begin
                    ph_q <= ph_q + 2'h1;
                    case (ph_q)
                        2'h0: begin
                            if (stg_q == SB_RDATA) begin
                                // ack all but the last byte [RULE_11]
                                oe_q <= (bit_q == BIT_ACK) && (rem_q != 8'h01);
                            end else begin
                                oe_q <= (bit_q != BIT_ACK) && !tx_q[7];
                            end
                        end
                        2'h1: scl_q <= 1'b1;
                        2'h2: begin
                            if (bit_q != BIT_ACK) begin
                                rx_q <= {rx_q[6:0], sda_sy_q[1]};
                            end
                            ack_q <= ~sda_sy_q[1]; // [RULE_02]
                        end
                        default: begin
                            scl_q <= 1'b0;
                            if (bit_q != BIT_ACK) begin
                                bit_q <= bit_q + 4'h1;
                                tx_q <= {tx_q[6:0], 1'b0};
                            end else begin
                                bit_q <= 4'h0;
                                if (stg_q == SB_RDATA) begin
                                    rdv_q <= 1'b1;
                                    rdd_q <= rx_q;
                                    if (rem_q == 8'h01) begin
                                        st_q <= SM_STOP; // [RULE_11]
                                    end else begin
                                        rem_q <= rem_q - 8'h01;
                                    end
                                end else if (!ack_q) begin
                                    nack_q <= 1'b1; // [RULE_02]
                                    st_q <= SM_STOP;
                                end else if (stg_q == SB_DEV) begin
                                    stg_q <= SB_ADDR; // [RULE_13]
                                    tx_q <= addr_q[7:0];
                                end else if (stg_q == SB_RDEV) begin
                                    stg_q <= SB_RDATA;
                                end else if (stg_q == SB_ADDR
                                        && op_q == SEP_OP_READ_RAND) begin
                                    stg_q <= SB_RDEV; // [RULE_14]
                                    ph_q <= 2'h0;
                                    st_q <= SM_START;
                                end else if (stg_q == SB_WDATA
                                        && rem_q == 8'h01) begin
                                    st_q <= SM_STOP;
                                end else begin
                                    if (stg_q == SB_WDATA) begin
                                        rem_q <= rem_q - 8'h01;
                                    end
                                    stg_q <= SB_WDATA;
                                    tx_q <= cmd_wdata;
                                    take_q <= 1'b1;
                                end
                            end
                        end
                    endcase
                end
                SM_STOP: if (tick) begin
                    ph_q <= ph_q + 2'h1;
                    case (ph_q)
                        2'h0: oe_q <= 1'b1;
                        2'h1: scl_q <= 1'b1;
                        2'h2: oe_q <= 1'b0;
                        default: begin
                            st_q <= SM_IDLE;
                            rdy_q <= 1'b1;
                            done_q <= 1'b1;
                        end
                    endcase
                end
                default: st_q <= SM_IDLE;
            endcase
        end
    end

    assign bus.scl = scl_q;
    assign bus.sda_m_o = 1'b0;
    assign bus.sda_m_oe = oe_q;
    assign cmd_ready = rdy_q;
    assign wd_take = take_q;
    assign rd_valid = rdv_q;
    assign rd_data = rdd_q;
    assign done = done_q;
    assign nack = nack_q;
endmodule // sep_mst
`default_nettype wire

// ==== sim/sep_link_props.sv ====
// checker: link and rewrite timer properties
`timescale 1ns/1ps
`default_nettype none
module sep_link_props #(
    parameter int WR_CYC = 5000
) (
    input wire logic clk, // system clock
    input wire logic reset, // async reset, high
    input wire logic scl, // link clock
    input wire logic sda, // resolved data line
    input wire logic sda_m_oe, // master pulls low
    input wire logic sda_d_oe, // device pulls low
    input wire logic busy // rewrite running
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    int busy_cnt_q;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            busy_cnt_q <= 0;
        end else begin
            busy_cnt_q <= busy ? busy_cnt_q + 1 : 0;
        end
    end
    busy_quiet_a: assert property (busy |-> !sda_d_oe)
        else $error("device drives data while rewriting");
    busy_len_a: assert property ($fell(busy) |-> busy_cnt_q == WR_CYC)
        else $error("rewrite time differs from setting");
    busy_cause_a: assert property ($rose(busy) |-> scl && sda)
        else $error("rewrite began without bus stop");
    busy_hold_a: assert property ($rose(busy) |-> busy[*8])
        else $error("rewrite ended early");
    dev_edge_a: assert property ($changed(sda_d_oe) |-> !scl)
        else $error("device changed data with clock high");
    scl_high_a: assert property ($rose(scl) |-> scl[*8])
        else $error("link clock high phase too short");
    cond_free_a: assert property (scl && $changed(sda_m_oe) |-> !sda_d_oe)
        else $error("device drove during start or stop");
    line_stable_a: assert property (
        scl && $past(scl) && $changed(sda) |-> $changed(sda_m_oe))
        else $error("data moved with clock high");
    cover property ($rose(busy));
    cover property (sda_d_oe && scl);
    cover property ($fell(busy));
endmodule // sep_link_props
`default_nettype wire

// ==== sim/testbench.sv ====
// testbench: master and eeprom ends joined by the link
`timescale 1ns/1ps
`default_nettype none
module testbench import sep_pkg::*;;
    localparam int WRC = 5000;
    localparam logic [2:0] STRAP = 3'b100;
    logic clk, reset, cmd_valid, wp;
    sep_op_e cmd_op;
    logic [2:0] cmd_dev;
    logic [8:0] cmd_addr;
    logic [7:0] cmd_len, cmd_wdata, rd_data, seen;
    logic cmd_ready, wd_take, rd_valid, done, nack, busy;
    int n_errors, total_checks;
    logic [7:0] wq[$];
    logic [7:0] rq[$];
    sep_if lnk();
    sep_mst #(.MEM_WORDS(512)) u_sep_mst (.clk(clk), .reset(reset),
        .bus(lnk), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
        .cmd_dev(cmd_dev), .cmd_addr(cmd_addr), .cmd_len(cmd_len),
        .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready), .wd_take(wd_take),
        .rd_valid(rd_valid), .rd_data(rd_data), .done(done), .nack(nack));
    sep_dev #(.MEM_WORDS(512), .WR_CYC(WRC)) u_sep_dev (.clk(clk),
        .reset(reset), .bus(lnk), .strap_addr(STRAP), .wp(wp), .busy(busy));
    sep_link_props #(.WR_CYC(WRC)) u_sep_link_props (.clk(clk),
        .reset(reset), .scl(lnk.scl), .sda(lnk.sda),
        .sda_m_oe(lnk.sda_m_oe), .sda_d_oe(lnk.sda_d_oe), .busy(busy));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic check(string what, logic [7:0] got, logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // one command, collecting read bytes, feeding write bytes
    task automatic run(sep_op_e op, logic [2:0] dev, logic [8:0] addr,
                       logic [7:0] len);
        rq.delete();
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_op <= op;
        cmd_dev <= dev;
        cmd_addr <= addr;
        cmd_len <= len;
        if (wq.size() > 0) begin
            cmd_wdata <= wq.pop_front();
        end
        @(posedge clk);
        cmd_valid <= 1'b0;
        do begin
            @(negedge clk);
            if (rd_valid === 1'b1) begin
                rq.push_back(rd_data);
            end
            if (wd_take === 1'b1 && wq.size() > 0) begin
                @(posedge clk);
                cmd_wdata <= wq.pop_front();
            end
        end while (done !== 1'b1);
    endtask
    task automatic wait_rewrite(output logic [7:0] rose);
        for (int t = 0; t < 50 && busy !== 1'b1; t++) @(negedge clk);
        rose = {7'h00, busy};
        for (int t = 0; t < WRC + 100 && busy !== 1'b0; t++) @(negedge clk);
    endtask
    task automatic sc_page_write_poll();
        wq = '{8'ha1, 8'hb2, 8'hc3};
        wp <= 1'b0;
        run(SEP_OP_WRITE, STRAP, 9'h1ff, 8'h03);
        check("write_nack", {7'h00, nack}, 8'h00);
        run(SEP_OP_READ_CUR, STRAP, 9'h000, 8'h01);
        check("poll_nack", {7'h00, nack}, 8'h01);
        check("poll_bytes", 8'(rq.size()), 8'h00);
        for (int t = 0; t < WRC + 100 && busy !== 1'b0; t++) @(negedge clk);
    endtask
    task automatic sc_protect();
        wq = '{8'hd4};
        wp <= 1'b1;
        run(SEP_OP_WRITE, STRAP, 9'h000, 8'h01);
        wait_rewrite(seen);
        check("low_busy", seen, 8'h01);
        wq = '{8'he5};
        run(SEP_OP_WRITE, STRAP, 9'h1f0, 8'h01);
        wait_rewrite(seen);
        check("prot_busy", seen, 8'h01);
        wp <= 1'b0;
    endtask
    task automatic sc_reads();
        run(SEP_OP_READ_RAND, STRAP, 9'h1f0, 8'h01);
        check("ack_after_busy", {7'h00, nack}, 8'h00);
        check("page_wrap_kept", rq[0], 8'hb2);
        check("page_wrap", rq[0], 8'hb2);
        run(SEP_OP_READ_CUR, STRAP, 9'h000, 8'h01);
        check("cur_ptr", rq[0], 8'hc3);
        run(SEP_OP_READ_RAND, STRAP, 9'h1ff, 8'h02);
        check("seq_first", rq[0], 8'ha1);
        check("seq_wrap", rq[1], 8'hd4);
    endtask
    task automatic sc_straps();
        run(SEP_OP_READ_CUR, 3'b010, 9'h000, 8'h01);
        check("bad_strap", {7'h00, nack}, 8'h01);
    endtask
    initial begin
        reset = 1'b1;
        cmd_valid = 1'b0;
        cmd_op = SEP_OP_WRITE;
        cmd_dev = 3'b000;
        cmd_addr = 9'h000;
        cmd_len = 8'h00;
        cmd_wdata = 8'h00;
        wp = 1'b0;
        n_errors = 0;
        total_checks = 0;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        sc_page_write_poll();
        sc_protect();
        sc_reads();
        sc_straps();
        give_verdict();
    end
    // hang guard, about 90k cycles
    initial begin
        #1_800_000;
        n_errors++;
        give_verdict();
    end
endmodule // testbench
`default_nettype wire
